// [verilog/fttz_pkg.sv]
/*
 * Constants, register map and types for the flow totalizer and batch dispenser.
 * Assumes one 25 MHz system clock and a 32-bit plain register port.
 */
// Overview of operation
// - Total limited to seven decimal digits.
// - Wrap mode restarts total from zero.
// - Hold mode freezes total until reset.
// - Overflow flag raised when enabled.
// - Elapsed timer freezes at its ceiling.
// - Reset command clears totals and timer.
// - Optional average rate since last reset.
// - Batch needs nonzero size and setpoint.
// - Show remaining quantity during a batch.
// - Raised batch size keeps flow going.
// - Lowered batch size stops flow immediately.
// - Zero setpoint pauses, timer keeps running.
// - Clearing batch leaves setpoint flowing.
// - Batch size kept in nonvolatile storage.
// - Over-ceiling flow counted at ceiling, flagged.
// - Missed-flow flag held until reset.
// - Sample 1000/s, refresh display 10/s.
// - Autotare after zero setpoint over two seconds.
package fttz_pkg;
	// Timing
	localparam int unsigned CLK_HZ = 25_000_000;
	localparam int unsigned TICK_RATE_HZ = 1000;
	localparam int unsigned TICK_CYCLES = CLK_HZ / TICK_RATE_HZ;
	localparam int unsigned DISPLAY_RATE_HZ = 10;
	localparam int unsigned DISPLAY_TICKS = TICK_RATE_HZ / DISPLAY_RATE_HZ;
	localparam int unsigned TARE_DELAY_MS = 2000;
	localparam int unsigned TARE_TICKS = TARE_DELAY_MS * TICK_RATE_HZ / 1000;
	localparam int unsigned CEIL_PCT = 128;
	// Widths
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned FLOW_W = 16;
	localparam int unsigned TOTAL_W = 24;
	localparam int unsigned SEC_W = 26;
	localparam int unsigned TICKS_W = 36;
	// Limits: 9,999,999 counts and 9999:59:59 in seconds
	localparam logic [TOTAL_W-1:0] TOTAL_MAX = 24'h98_967F;
	localparam logic [SEC_W-1:0] TIMER_MAX_SEC = 26'h225_50FF;
	localparam logic [FLOW_W-1:0] FLOW_FULL_SCALE = 16'h2710;
	// Register byte offsets
	localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] REG_SETPT = 8'h04;
	localparam logic [ADDR_W-1:0] REG_BATCH = 8'h08;
	localparam logic [ADDR_W-1:0] REG_STATUS = 8'h0C;
	localparam logic [ADDR_W-1:0] REG_TOTAL = 8'h10;
	localparam logic [ADDR_W-1:0] REG_TIMER = 8'h14;
	localparam logic [ADDR_W-1:0] REG_REMAIN = 8'h18;
	localparam logic [ADDR_W-1:0] REG_AVG = 8'h1C;
	localparam logic [ADDR_W-1:0] REG_TARE = 8'h20;
	// Control fields
	localparam int unsigned CTRL_HOLD_BIT = 0;
	localparam int unsigned CTRL_OVF_ERR_BIT = 1;
	localparam int unsigned CTRL_AUTOTARE_BIT = 2;
	localparam int unsigned CTRL_AVG_BIT = 3;
	localparam int unsigned CTRL_RESET_BIT = 4;
	localparam logic [3:0] CTRL_RESET_VAL = 4'hE;
	// Status fields
	localparam int unsigned ST_OVF_BIT = 0;
	localparam int unsigned ST_MISSED_BIT = 1;
	localparam int unsigned ST_DONE_BIT = 2;
	localparam int unsigned ST_FLOW_BIT = 3;
	localparam int unsigned ST_TARED_BIT = 4;
	// Average divider states
	typedef enum logic {DIV_IDLE, DIV_RUN} fttz_div_state_type;
endpackage : fttz_pkg

// [verilog/fttz_totalizer.sv]
/*
 * Flow totalizer, elapsed timer, average rate, autotare and batch dispenser.
 * Assumes synchronous inputs, a flow sample already scaled to total counts per
 * tick, and an external nonvolatile store that offers the saved batch size.
 */
// The address map and the strobed register port are this design's own decisions.
module fttz_totalizer #(
	parameter int unsigned TICK_CYCLES_P = fttz_pkg::TICK_CYCLES,
	parameter logic [fttz_pkg::FLOW_W-1:0] FULL_SCALE_P = fttz_pkg::FLOW_FULL_SCALE
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic [fttz_pkg::ADDR_W-1:0] i_addr,
	input wire logic [fttz_pkg::DATA_W-1:0] i_wr_data,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [fttz_pkg::DATA_W-1:0] o_rd_data,
	input wire logic [fttz_pkg::FLOW_W-1:0] i_flow_raw,
	input wire logic [fttz_pkg::TOTAL_W-1:0] i_nv_batch,
	output logic o_nv_write,
	output logic [fttz_pkg::TOTAL_W-1:0] o_nv_data,
	output logic [fttz_pkg::FLOW_W-1:0] o_valve_setpoint,
	output logic o_flow_enable,
	output logic o_batch_done,
	output logic o_total_overflow_flag,
	output logic o_missed_flow_flag,
	output logic o_display_strobe
);
	import fttz_pkg::*;

	localparam logic [FLOW_W+7:0] CEIL_WIDE = 24'((FULL_SCALE_P * CEIL_PCT) / 100);
	localparam logic [TOTAL_W-1:0] FLOW_CEIL = CEIL_WIDE;

	// Refuse tick periods the counter cannot serve
	if (TICK_CYCLES_P < 2 || TICK_CYCLES_P > 65536) begin : g_bad_tick
		$error("TICK_CYCLES_P out of range");
	end

	// Floor subtraction, shared by tare removal and remaining quantity
	function automatic logic [TOTAL_W-1:0] sub_floor(input logic [TOTAL_W-1:0] a, input logic [TOTAL_W-1:0] b);
		sub_floor = (a > b) ? a - b : '0;
	endfunction : sub_floor

	logic rst_meta; // First reset stage, read only by the second
	logic rst_b; // Synchronised reset used everywhere else
	logic [3:0] ctrl; // Hold, overflow error, autotare, average enables
	logic reset_cmd; // One-cycle totalizer reset pulse
	logic [FLOW_W-1:0] setpoint; // Operator setpoint
	logic [TOTAL_W-1:0] batch_size; // Zero means no batch
	logic nv_loaded; // Saved batch size taken after reset release
	logic [15:0] tick_cnt; // Divides clock down to the sample rate
	logic tick; // One-cycle pulse per measurement sample
	logic [TOTAL_W-1:0] tare_offset; // Zero reference of the flow reading
	logic tared; // A tare has been taken
	logic [11:0] zero_cnt; // Ticks spent at zero setpoint
	logic [TOTAL_W-1:0] total; // Accumulated flow
	logic [SEC_W-1:0] secs; // Elapsed whole seconds
	logic [9:0] sub_ticks; // Ticks within the current second
	logic [TICKS_W-1:0] ticks_run; // Ticks since last reset, average divisor
	logic [6:0] disp_cnt; // Ticks within one display period
	logic [TOTAL_W-1:0] remain; // Quantity still to dispense
	logic [TOTAL_W-1:0] avg_rate; // mass_average_rate, counts per tick
	fttz_div_state_type div_state; // Serial divider state
	logic [4:0] div_step; // Remaining quotient bits
	logic [TICKS_W:0] div_rem; // Partial remainder
	logic [TOTAL_W-1:0] div_quo; // Dividend in, quotient out
	logic [TICKS_W-1:0] div_den; // Latched divisor
	logic [TOTAL_W-1:0] net_flow; // Flow after tare
	logic [TOTAL_W-1:0] eff_flow; // Flow after ceiling clamp
	logic over_ceil; // Sample beyond measurable range
	logic [TOTAL_W:0] sum; // Total plus this sample
	logic [TOTAL_W-1:0] total_wrapped; // Sum restarted past the maximum
	logic [TICKS_W:0] div_trial; // Divider trial remainder
	logic batch_active; // A batch size is set
	logic next_done; // Total has reached the batch size
	logic next_flow; // Flow allowed this cycle

	// Tare removal, ceiling clamp and the running sum
	always_comb begin
		net_flow = sub_floor({8'h00, i_flow_raw}, tare_offset);
		over_ceil = net_flow > FLOW_CEIL;
		eff_flow = over_ceil ? FLOW_CEIL : net_flow;
		sum = {1'b0, total} + {1'b0, eff_flow};
		total_wrapped = TOTAL_W'(sum - {1'b0, TOTAL_MAX} - 25'h00_0001);
		div_trial = {div_rem[TICKS_W-1:0], div_quo[TOTAL_W-1]};
		batch_active = batch_size != '0;
		next_done = batch_active && (total >= batch_size);
		next_flow = (setpoint != '0) && !next_done;
	end

	// Reset release through two flip-flops
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rst_meta <= 1'b0;
			rst_b <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_b <= rst_meta;
		end
	end

	// Control and setpoint registers; reset bit is a self-clearing pulse
	always_ff @(posedge i_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl <= CTRL_RESET_VAL;
			reset_cmd <= 1'b0;
			setpoint <= '0;
		end else begin
			reset_cmd <= i_wr && (i_addr == REG_CTRL) && i_wr_data[CTRL_RESET_BIT];
			if (i_wr && i_addr == REG_CTRL) begin
				ctrl <= i_wr_data[3:0];
			end
			if (i_wr && i_addr == REG_SETPT) begin
				setpoint <= i_wr_data[FLOW_W-1:0];
			end
		end
	end

	// Batch size: restored from the store once, every later write mirrored back to it
	always_ff @(posedge i_clk or negedge rst_b) begin
		if (!rst_b) begin
			batch_size <= '0;
			nv_loaded <= 1'b0;
			o_nv_write <= 1'b0;
			o_nv_data <= '0;
		end else begin
			o_nv_write <= 1'b0;
			if (!nv_loaded) begin
				// Caught after release, never under the asynchronous reset
				nv_loaded <= 1'b1;
				batch_size <= i_nv_batch;
			end else if (i_wr && i_addr == REG_BATCH) begin
				batch_size <= i_wr_data[TOTAL_W-1:0];
				o_nv_write <= 1'b1;
				o_nv_data <= i_wr_data[TOTAL_W-1:0];
			end
		end
	end

	// Sample tick generator
	always_ff @(posedge i_clk or negedge rst_b) begin
		if (!rst_b) begin
			tick_cnt <= '0;
			tick <= 1'b0;
		end else begin
			tick <= tick_cnt == 16'(TICK_CYCLES_P - 1);
			tick_cnt <= (tick_cnt == 16'(TICK_CYCLES_P - 1)) ? '0 : tick_cnt + 16'h0001;
		end
	end

	// Autotare: zero reference taken once the setpoint has sat at zero too long
	always_ff @(posedge i_clk or negedge rst_b) begin
		if (!rst_b) begin
			zero_cnt <= '0;
			tare_offset <= '0;
			tared <= 1'b0;
		end else if (setpoint != '0) begin
			zero_cnt <= '0;
		end else if (tick && zero_cnt <= 12'(TARE_TICKS)) begin
			zero_cnt <= zero_cnt + 12'h001;
			if (zero_cnt == 12'(TARE_TICKS) && ctrl[CTRL_AUTOTARE_BIT]) begin
				tare_offset <= {8'h00, i_flow_raw};
				tared <= 1'b1;
			end
		end
	end

	// Accumulated total with wrap or hold at the seven-digit maximum
	always_ff @(posedge i_clk or negedge rst_b) begin
		if (!rst_b) begin
			total <= '0;
		end else if (reset_cmd) begin
			total <= '0;
		end else if (tick) begin
			if (sum > {1'b0, TOTAL_MAX}) begin
				total <= ctrl[CTRL_HOLD_BIT] ? TOTAL_MAX : total_wrapped;
			end else begin
				total <= sum[TOTAL_W-1:0];
			end
		end
	end

	// Sticky flags: a set in the cycle of a reset command wins
	always_ff @(posedge i_clk or negedge rst_b) begin
		if (!rst_b) begin
			o_total_overflow_flag <= 1'b0;
			o_missed_flow_flag <= 1'b0;
		end else begin
			if (tick && ctrl[CTRL_OVF_ERR_BIT] && sum >= {1'b0, TOTAL_MAX}) begin
				o_total_overflow_flag <= 1'b1;
			end else if (reset_cmd) begin
				o_total_overflow_flag <= 1'b0;
			end
			if (tick && over_ceil) begin
				o_missed_flow_flag <= 1'b1;
			end else if (reset_cmd) begin
				o_missed_flow_flag <= 1'b0;
			end
		end
	end

	// Elapsed timer runs regardless of valve state and freezes at its ceiling
	always_ff @(posedge i_clk or negedge rst_b) begin
		if (!rst_b) begin
			secs <= '0;
			sub_ticks <= '0;
			ticks_run <= '0;
		end else if (reset_cmd) begin
			secs <= '0;
			sub_ticks <= '0;
			ticks_run <= '0;
		end else if (tick && secs != TIMER_MAX_SEC) begin
			ticks_run <= ticks_run + 36'h0_0000_0001;
			if (sub_ticks == 10'(TICK_RATE_HZ - 1)) begin
				sub_ticks <= '0;
				secs <= secs + 26'h000_0001;
			end else begin
				sub_ticks <= sub_ticks + 10'h001;
			end
		end
	end

	// Display refresh strobe, one per DISPLAY_TICKS samples
	always_ff @(posedge i_clk or negedge rst_b) begin
		if (!rst_b) begin
			disp_cnt <= '0;
			o_display_strobe <= 1'b0;
		end else begin
			o_display_strobe <= tick && disp_cnt == 7'(DISPLAY_TICKS - 1);
			if (tick) begin
				disp_cnt <= (disp_cnt == 7'(DISPLAY_TICKS - 1)) ? '0 : disp_cnt + 7'h01;
			end
		end
	end

	// Batch control and valve command; pause keeps the batch, done stops flow
	always_ff @(posedge i_clk or negedge rst_b) begin
		if (!rst_b) begin
			o_batch_done <= 1'b0;
			o_flow_enable <= 1'b0;
			o_valve_setpoint <= '0;
			remain <= '0;
		end else begin
			o_batch_done <= next_done;
			o_flow_enable <= next_flow;
			o_valve_setpoint <= next_flow ? setpoint : '0;
			remain <= batch_active ? sub_floor(batch_size, total) : '0;
		end
	end

	// Average rate by a serial divider; one result every TOTAL_W+1 cycles.
	// A serial divider costs latency, but the average only feeds a 10/s display.
	always_ff @(posedge i_clk or negedge rst_b) begin
		if (!rst_b) begin
			div_state <= DIV_IDLE;
			div_step <= '0;
			div_rem <= '0;
			div_quo <= '0;
			div_den <= '0;
			avg_rate <= '0;
		end else begin
			case (div_state)
				DIV_IDLE: begin
					div_quo <= total;
					div_den <= ticks_run;
					div_rem <= '0;
					div_step <= 5'(TOTAL_W);
					div_state <= DIV_RUN;
				end
				DIV_RUN: begin
					if (div_trial >= {1'b0, div_den}) begin
						div_rem <= div_trial - {1'b0, div_den};
						div_quo <= {div_quo[TOTAL_W-2:0], 1'b1};
					end else begin
						div_rem <= div_trial;
						div_quo <= {div_quo[TOTAL_W-2:0], 1'b0};
					end
					div_step <= div_step - 5'h01;
					if (div_step == 5'h01) begin
						div_state <= DIV_IDLE;
					end
				end
				default: begin
					div_state <= DIV_IDLE;
				end
			endcase
			if (reset_cmd || !ctrl[CTRL_AVG_BIT] || div_den == '0) begin
				avg_rate <= '0;
			end else if (div_state == DIV_RUN && div_step == 5'h01) begin
				avg_rate <= {div_quo[TOTAL_W-2:0], div_trial >= {1'b0, div_den}};
			end
		end
	end

	// Read data one cycle after the strobe; unmapped offsets read zero
	always_ff @(posedge i_clk or negedge rst_b) begin
		if (!rst_b) begin
			o_rd_data <= '0;
		end else if (i_rd) begin
			case (i_addr)
				REG_CTRL: o_rd_data <= {28'h000_0000, ctrl};
				REG_SETPT: o_rd_data <= {16'h0000, setpoint};
				REG_BATCH: o_rd_data <= {8'h00, batch_size};
				REG_STATUS: o_rd_data <= {27'h000_0000, tared, o_flow_enable, o_batch_done,
					o_missed_flow_flag, o_total_overflow_flag};
				REG_TOTAL: o_rd_data <= {8'h00, total};
				REG_TIMER: o_rd_data <= {6'h00, secs};
				REG_REMAIN: o_rd_data <= {8'h00, remain};
				REG_AVG: o_rd_data <= {8'h00, avg_rate};
				REG_TARE: o_rd_data <= {8'h00, tare_offset};
				default: o_rd_data <= '0;
			endcase
		end else begin
			o_rd_data <= '0;
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!rst_b);

	a_total_in_range: assert property (total <= TOTAL_MAX)
		else $error("total beyond seven digits");
	a_wrap_restart: assert property (tick && !reset_cmd && !ctrl[CTRL_HOLD_BIT] && sum > {1'b0, TOTAL_MAX}
		|=> total == $past(total_wrapped)) else $error("total did not wrap");
	a_hold_at_max: assert property (ctrl[CTRL_HOLD_BIT] && total == TOTAL_MAX && !reset_cmd
		|=> total == TOTAL_MAX) else $error("held total moved");
	a_overflow_flag_set: assert property (tick && ctrl[CTRL_OVF_ERR_BIT] && sum >= {1'b0, TOTAL_MAX}
		|=> o_total_overflow_flag) else $error("overflow flag missing");
	a_timer_freeze: assert property (secs == TIMER_MAX_SEC && !reset_cmd |=> $stable(secs))
		else $error("timer moved past ceiling");
	a_reset_clears: assert property (reset_cmd && !tick |=> total == '0 && secs == '0 && !o_missed_flow_flag)
		else $error("reset command did not clear");
	a_idle_batch: assert property (setpoint == '0 |=> !o_flow_enable && o_valve_setpoint == '0)
		else $error("flow with zero setpoint");
	a_remain_value: assert property (batch_active && total <= batch_size
		|=> remain == $past(batch_size) - $past(total))
		else $error("remaining quantity wrong");
	a_batch_stop: assert property (batch_active && total >= batch_size |=> o_batch_done && !o_flow_enable)
		else $error("batch did not stop flow");
	a_missed_set: assert property (tick && over_ceil |=> o_missed_flow_flag ##1 o_missed_flow_flag[*2] or reset_cmd)
		else $error("missed flow not flagged");
	a_missed_sticky: assert property (o_missed_flow_flag && !reset_cmd |=> o_missed_flow_flag)
		else $error("missed flow flag dropped");
	a_tare_capture: assert property (tick && setpoint == '0 && zero_cnt == 12'(TARE_TICKS)
		&& ctrl[CTRL_AUTOTARE_BIT] |=> tared && tare_offset == {8'h00, $past(i_flow_raw)})
		else $error("autotare not taken");

	c_batch_done: cover property (o_flow_enable ##1 o_batch_done);
	c_total_wrap: cover property (tick && !ctrl[CTRL_HOLD_BIT] && sum > {1'b0, TOTAL_MAX});
	c_autotare: cover property ($rose(tared));
	c_missed_flow: cover property ($rose(o_missed_flow_flag));
endmodule : fttz_totalizer

// [tb/fttz_flow_model.sv]
/*
 * Far side of the totalizer: flow sensor behind the valve, and the nonvolatile store.
 * Assumes the bench clock. Sensor flow follows the valve one cycle late.
 */
module fttz_flow_model #(
	parameter logic [fttz_pkg::TOTAL_W-1:0] NV_INIT = 24'h00_0123
) (
	input wire logic i_clk,
	input wire logic [fttz_pkg::FLOW_W-1:0] i_valve_setpoint,
	input wire logic i_flow_enable,
	input wire logic [fttz_pkg::FLOW_W-1:0] i_leak,
	input wire logic i_surge,
	input wire logic i_nv_write,
	input wire logic [fttz_pkg::TOTAL_W-1:0] i_nv_data,
	output logic [fttz_pkg::FLOW_W-1:0] o_flow_raw,
	output logic [fttz_pkg::TOTAL_W-1:0] o_nv_batch
);
	timeunit 1ns;
	timeprecision 1ps;
	import fttz_pkg::*;
	// Sensor starts defined, so the first sample is never unknown; one process drives it.
	// Valve flow plus zero drift; a surge reads far above the ceiling
	initial begin
		o_flow_raw = 16'h0000;
		forever begin
			@(posedge i_clk);
			if (i_surge) begin
				o_flow_raw <= 16'hFFFF;
			end else begin
				o_flow_raw <= (i_flow_enable ? i_valve_setpoint : 16'h0000) + i_leak;
			end
		end
	end
	// Saved batch size starts at its stored value and outlives any reset of the design
	initial begin
		o_nv_batch = NV_INIT;
		forever begin
			@(posedge i_clk);
			if (i_nv_write) begin
				o_nv_batch <= i_nv_data;
			end
		end
	end
endmodule : fttz_flow_model

// [tb/test_flow_totalizer_batch_dispenser.sv]
/*
 * Self-checking bench for the flow totalizer and batch dispenser.
 * Assumes the package, the design and the flow model are compiled before it.
 */
module test_flow_totalizer_batch_dispenser;
	timeunit 1ns;
	timeprecision 1ps;
	import fttz_pkg::*;
	localparam int TICK = 8; // Short sample period keeps the run small
	localparam int LIMIT = 90000; // Cycle ceiling, about two and a half times the expected run
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [ADDR_W-1:0] addr = '0;
	logic [DATA_W-1:0] wr_data = '0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [DATA_W-1:0] rd_data;
	logic [FLOW_W-1:0] flow_raw, valve, leak = '0;
	logic surge = 1'b0;
	logic [TOTAL_W-1:0] nv_batch, nv_data;
	logic nv_write, flow_en, done, ovf, missed, disp;
	int num_errors = 0;
	int n_checks = 0;
	int cyc = 0;
	logic [15:0] seed = 16'h0026;
	int sizes[$];
	int rates[$];
	fttz_totalizer #(.TICK_CYCLES_P(TICK), .FULL_SCALE_P(FLOW_FULL_SCALE)) dut_u (.i_clk(clk), .i_rst_b(rst_b),
		.i_addr(addr), .i_wr_data(wr_data), .i_wr(wr), .i_rd(rd), .o_rd_data(rd_data), .i_flow_raw(flow_raw),
		.i_nv_batch(nv_batch), .o_nv_write(nv_write), .o_nv_data(nv_data), .o_valve_setpoint(valve),
		.o_flow_enable(flow_en), .o_batch_done(done), .o_total_overflow_flag(ovf), .o_missed_flow_flag(missed),
		.o_display_strobe(disp));
	fttz_flow_model flow_u (.i_clk(clk), .i_valve_setpoint(valve), .i_flow_enable(flow_en), .i_leak(leak),
		.i_surge(surge), .i_nv_write(nv_write), .i_nv_data(nv_data), .o_flow_raw(flow_raw), .o_nv_batch(nv_batch));
	// 25 MHz clock
	always #20 clk = ~clk;
	// Pseudo-random source for batch sizes and rates
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr_next
	task report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : report_and_stop
	// A hang is cut short here and counted as a mismatch
	always @(posedge clk) begin
		cyc++;
		if (cyc == LIMIT) begin
			num_errors++;
			$display("ERROR cycle limit expected end seen %0d cycles", cyc);
			report_and_stop();
		end
	end
	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	// One-cycle write strobe, changed just after the edge
	task wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wr_data <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	// Read data stand only in the cycle after the strobe, so look mid-cycle
	task rd_chk(input string name, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk(name, rd_data, exp);
	endtask : rd_chk
	task settle(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask : settle
	// Bounded wait for a design level, sampled away from the edge
	task automatic wait_true(input string name, ref logic s, input int lim);
		int n = 0;
		while (s !== 1'b1 && n < lim) begin
			@(negedge clk);
			n++;
		end
		chk(name, 32'(s), 32'h0000_0001);
	endtask : wait_true
	task end_test(input string name);
		$display("test %s finished, %0d mismatches so far", name, num_errors);
	endtask : end_test
	initial begin
		int b, s, exp_total, n;
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		repeat (6) @(posedge clk);
		rd_chk("ctrl reset", REG_CTRL, {28'h000_0000, CTRL_RESET_VAL});
		rd_chk("saved batch", REG_BATCH, 32'h0000_0123);
		rd_chk("unmapped", 8'h24, 32'h0000_0000);
		end_test("registers");
		for (int k = 0; k < 3; k++) begin
			seed = lfsr_next(seed);
			sizes.push_back(256 + int'(seed % 2048));
			seed = lfsr_next(seed);
			rates.push_back(16 + int'(seed % 240));
		end
		foreach (sizes[k]) begin
			b = sizes[k];
			s = rates[k];
			exp_total = ((b + s - 1) / s) * s;
			wr_reg(REG_SETPT, 32'h0000_0000);
			wr_reg(REG_BATCH, 32'(b));
			wr_reg(REG_CTRL, 32'h0000_001E);
			settle(2);
			chk("idle flow", 32'(flow_en), 32'h0000_0000);
			rd_chk("remain", REG_REMAIN, 32'(b));
			rd_chk("timer", REG_TIMER, 32'h0000_0000);
			wr_reg(REG_SETPT, 32'(s));
			wait_true("done", done, 3000);
			rd_chk("batch total", REG_TOTAL, 32'(exp_total));
			chk("stop flow", 32'(flow_en), 32'h0000_0000);
			chk("stop valve", 32'(valve), 32'h0000_0000);
			wr_reg(REG_BATCH, 32'(exp_total + 3 * s));
			settle(2);
			chk("raised", 32'(flow_en), 32'h0000_0001);
			wait_true("done raised", done, 600);
			rd_chk("raised total", REG_TOTAL, 32'(exp_total + 3 * s));
			wr_reg(REG_BATCH, 32'h0080_0000);
			wr_reg(REG_SETPT, 32'h0000_0000);
			settle(2);
			chk("pause", 32'(flow_en), 32'h0000_0000);
			chk("pause done", 32'(done), 32'h0000_0000);
			wr_reg(REG_SETPT, 32'(s));
			settle(2);
			chk("resume", 32'(flow_en), 32'h0000_0001);
			wr_reg(REG_BATCH, 32'h0000_0001);
			settle(2);
			chk("lowered", 32'(flow_en), 32'h0000_0000);
			wr_reg(REG_BATCH, 32'h0000_0000);
			settle(2);
			chk("cleared", 32'(flow_en), 32'h0000_0001);
			chk("cleared valve", 32'(valve), 32'(s));
			wr_reg(REG_SETPT, 32'h0000_0000);
			end_test("batch");
		end
		chk("nv store", 32'(nv_batch), 32'h0000_0000);
		// Freeze mode: full-scale flow drives the total into its ceiling
		wr_reg(REG_CTRL, 32'h0000_001F);
		wr_reg(REG_SETPT, 32'(FLOW_FULL_SCALE));
		wait_true("hold flag", ovf, 9000);
		rd_chk("hold total", REG_TOTAL, 32'(TOTAL_MAX));
		// Overflow flag and flow enable up; no batch, no miss, no tare taken yet
		rd_chk("status", REG_STATUS, 32'h0000_0009);
		wr_reg(REG_CTRL, 32'h0000_0007);
		settle(40);
		rd_chk("avg off", REG_AVG, 32'h0000_0000);
		rd_chk("held total", REG_TOTAL, 32'(TOTAL_MAX));
		// Wrap mode: 1000 ticks of 10000 land exactly on zero. Leave the held maximum a tick
		// before the reset, since a tick at the maximum in the reset cycle sets the flag again.
		wr_reg(REG_CTRL, 32'h0000_000C);
		settle(TICK);
		wr_reg(REG_CTRL, 32'h0000_001E);
		settle(2);
		chk("flag cleared", 32'(ovf), 32'h0000_0000);
		// Constant flow since the reset: the average equals it once a later division lands
		settle(80);
		rd_chk("avg rate", REG_AVG, 32'(FLOW_FULL_SCALE));
		wait_true("wrap flag", ovf, 9000);
		rd_chk("wrap total", REG_TOTAL, 32'h0000_0000);
		end_test("overflow");
		wr_reg(REG_SETPT, 32'h0000_0000);
		settle(3 * TICK);
		wr_reg(REG_CTRL, 32'h0000_001E);
		surge <= 1'b1;
		wait_true("missed", missed, 4 * TICK);
		rd_chk("clamped", REG_TOTAL, 32'(FLOW_FULL_SCALE * CEIL_PCT / 100));
		@(posedge clk);
		surge <= 1'b0;
		settle(3 * TICK);
		chk("missed held", 32'(missed), 32'h0000_0001);
		wr_reg(REG_CTRL, 32'h0000_001E);
		settle(2);
		chk("missed clear", 32'(missed), 32'h0000_0000);
		end_test("missed flow");
		wait_true("strobe", disp, 1000);
		settle(1);
		n = 1;
		while (disp !== 1'b1 && n < 1000) begin
			@(negedge clk);
			n++;
		end
		chk("strobe gap", 32'(n), 32'(DISPLAY_TICKS * TICK));
		end_test("display");
		// Drift on a closed valve must be tared out after the zero period
		@(posedge clk);
		leak <= 16'h0005;
		settle(TARE_TICKS * TICK + 10 * TICK);
		rd_chk("tare", REG_TARE, 32'h0000_0005);
		wr_reg(REG_CTRL, 32'h0000_001E);
		settle(5 * TICK);
		rd_chk("tared total", REG_TOTAL, 32'h0000_0000);
		end_test("autotare");
		report_and_stop();
	end
endmodule : test_flow_totalizer_batch_dispenser
